// >>> tb/tb_wut_timer.sv
// self-checking register-level testbench of the wake-up counter
`define CHK(nm, ex, ac) begin comparisons++; if ((ac) !== (ex)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, ex, ac); end end
module tb_wut_timer;
    timeunit 1ns;
    timeprecision 100ps;
    import wut_pkg::*;

    // ************************************************************
    // clock, reset, design
    // ************************************************************
    logic              mclk = 1'b0;
    logic              rst = 1'b1;
    wut_bus_t          bus = '0;
    logic [31:0]       rdata;
    logic              xtal_tick = 1'b0;
    logic              osc_tick = 1'b0;
    logic              core_clk_off = 1'b0;
    logic [2:0]        core_clock_divider = 3'h0;
    logic              irq;
    logic              adc_trigger;
    int                fail_count = 0;
    int                comparisons = 0;
    int                adc_n = 0;
    logic [31:0]       rv;
    logic [3:0]        psc_tab [4] = '{PSC_DIV1, PSC_DIV16, PSC_DIV256, PSC_DIV32K};
    logic [14:0]       last_tab [4] = '{LAST_DIV1, LAST_DIV16, LAST_DIV256, LAST_DIV32K};
    logic [31:0]       hl_tab [4] = '{32'h00000100, 32'h173b3b63, 32'h173b3b63, 32'h00000000};
    logic              hu_tab [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wut_fmt_t          hf_tab [4] = '{FMT_HMS23, FMT_HMS23, FMT_HMS255, FMT_HMS23};
    logic [31:0]       he_tab [4] = '{32'h00000063, 32'h00000000, 32'h18000000, 32'h173b3b63};
    logic              hi_tab [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [1:0]        src_tab [3] = '{2'b00, 2'b01, 2'b10};

    always #5 mclk = ~mclk;

    wut_timer dut (
        .mclk               (mclk),
        .rst                (rst),
        .bus                (bus),
        .rdata              (rdata),
        .xtal_tick          (xtal_tick),
        .osc_tick           (osc_tick),
        .core_clk_off       (core_clk_off),
        .core_clock_divider (core_clock_divider),
        .irq                (irq),
        .adc_trigger        (adc_trigger)
    );

    // each converter trigger is a one-cycle pulse, so counting high cycles counts timeouts
    always @(posedge mclk) begin
        if (adc_trigger === 1'b1)
            adc_n++;
    end

    // ************************************************************
    // bus and stimulus tasks
    // ************************************************************
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        rd_reg(a, d);
        `CHK(nm, e, d)
    endtask

    // n source ticks back to back, then room for the two-cycle count latency
    task automatic ticks(input logic use_osc, input int n);
        if (n > 0) begin
            @(posedge mclk);
            if (use_osc)
                osc_tick <= 1'b1;
            else
                xtal_tick <= 1'b1;
            repeat (n) @(posedge mclk);
            osc_tick <= 1'b0;
            xtal_tick <= 1'b0;
        end
        repeat (4) @(posedge mclk);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] s, input logic up, input logic en,
                                        input logic per, input logic [1:0] f,
                                        input logic [3:0] p);
        ctl = {21'h000000, s, up, en, per, f, p};
    endfunction

    task automatic complete_run;
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ************************************************************
    // watchdog: the longest test is one 32768-tick prescale period
    // ************************************************************
    initial begin
        #600000;
        fail_count++;
        complete_run;
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        chk_rd(LOAD_OFS, LOAD_RST, "load reset");
        chk_rd(COUNT_OFS, COUNT_RST, "count reset");
        chk_rd(CTRL_OFS, 32'h00000000, "control reset");
        chk_rd(ICLR_OFS, 32'h00000000, "clear reads zero");
        chk_rd(STAT_OFS, 32'h00000000, "status reset");
        chk_rd(MASK_OFS, 32'h00000001, "mask reset");
        chk_rd(32'hffff0358, 32'h00000000, "unmapped read");
        `CHK("irq reset", 1'b0, irq)
        wr_reg(COUNT_OFS, 32'h00001234);
        chk_rd(COUNT_OFS, COUNT_RST, "count write ignored");
        wr_reg(LOAD_OFS, 32'h00000003);
        chk_rd(COUNT_OFS, 32'h00000003, "load sets count");
        ticks(1'b1, 2);
        chk_rd(COUNT_OFS, 32'h00000003, "halted count");
        // free-running down count through the terminal value
        wr_reg(CTRL_OFS, ctl(SRC_OSC, 1'b0, 1'b1, 1'b0, FMT_BIN, PSC_DIV1));
        chk_rd(CTRL_OFS, ctl(SRC_OSC, 1'b0, 1'b1, 1'b0, FMT_BIN, PSC_DIV1), "control");
        ticks(1'b1, 1);
        chk_rd(COUNT_OFS, 32'h00000002, "count down");
        ticks(1'b0, 1);
        chk_rd(COUNT_OFS, 32'h00000002, "other source");
        ticks(1'b1, 2);
        `CHK("no irq before", 1'b0, irq)
        ticks(1'b1, 1);
        chk_rd(COUNT_OFS, 32'hffffffff, "free wrap");
        `CHK("irq at timeout", 1'b1, irq)
        `CHK("trigger count", 1, adc_n)
        // mask hides the interrupt but not the pending status, write-one clears it
        wr_reg(MASK_OFS, 32'h00000000);
        chk_rd(STAT_OFS, 32'h00000001, "status sticky");
        `CHK("irq masked", 1'b0, irq)
        wr_reg(MASK_OFS, 32'h00000001);
        chk_rd(STAT_OFS, 32'h00000001, "status held");
        `CHK("irq unmasked", 1'b1, irq)
        wr_reg(STAT_OFS, 32'h00000001);
        chk_rd(STAT_OFS, 32'h00000000, "status cleared");
        `CHK("irq after w1c", 1'b0, irq)
        // periodic reload
        wr_reg(LOAD_OFS, 32'h00000002);
        wr_reg(CTRL_OFS, ctl(SRC_OSC, 1'b0, 1'b1, 1'b1, FMT_BIN, PSC_DIV1));
        ticks(1'b1, 3);
        chk_rd(COUNT_OFS, 32'h00000002, "periodic reload");
        `CHK("irq periodic", 1'b1, irq)
        `CHK("trigger periodic", 2, adc_n)
        wr_reg(ICLR_OFS, 32'h0000005a);
        repeat (2) @(posedge mclk);
        `CHK("irq cleared", 1'b0, irq)
        // up count wraps through full scale
        wr_reg(LOAD_OFS, 32'hfffffffe);
        wr_reg(CTRL_OFS, ctl(SRC_OSC, 1'b1, 1'b1, 1'b0, FMT_BIN, PSC_DIV1));
        ticks(1'b1, 1);
        chk_rd(COUNT_OFS, 32'hffffffff, "count up");
        ticks(1'b1, 1);
        chk_rd(COUNT_OFS, 32'h00000000, "up wrap");
        `CHK("irq up", 1'b1, irq)
        // crystal and oscillator keep counting with the core clock gated
        @(posedge mclk);
        core_clk_off <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            wr_reg(LOAD_OFS, 32'h0000000a);
            wr_reg(CTRL_OFS, ctl(src_tab[s], 1'b0, 1'b1, 1'b0, FMT_BIN, PSC_DIV1));
            ticks(s == 2, 1);
            chk_rd(COUNT_OFS, 32'h00000009, "selected source");
            ticks(s != 2, 1);
            chk_rd(COUNT_OFS, 32'h00000009, "other source");
        end
        // core source: frozen while gated, a tick every fourth cycle otherwise
        @(posedge mclk);
        core_clock_divider <= 3'h2;
        wr_reg(LOAD_OFS, 32'h000003e8);
        wr_reg(CTRL_OFS, ctl(SRC_CORE, 1'b0, 1'b1, 1'b0, FMT_BIN, PSC_DIV1));
        repeat (40) @(posedge mclk);
        chk_rd(COUNT_OFS, 32'h000003e8, "core gated");
        @(posedge mclk);
        core_clk_off <= 1'b0;
        repeat (40) @(posedge mclk);
        rd_reg(COUNT_OFS, rv);
        `CHK("core rate", 1'b1, (rv <= 32'h000003df && rv >= 32'h000003d9))
        // prescaler: one step per full period, none a tick earlier
        for (int i = 0; i < 4; i++) begin
            wr_reg(CTRL_OFS, 32'h00000000);
            wr_reg(LOAD_OFS, 32'h00000064);
            wr_reg(CTRL_OFS, ctl(SRC_OSC, 1'b0, 1'b1, 1'b0, FMT_BIN, psc_tab[i]));
            ticks(1'b1, int'(last_tab[i]));
            chk_rd(COUNT_OFS, 32'h00000064, "prescale hold");
            ticks(1'b1, 1);
            chk_rd(COUNT_OFS, 32'h00000063, "prescale step");
        end
        // time-of-day formats, with the divide-by-256 prescale software is asked to use
        for (int i = 0; i < 4; i++) begin
            wr_reg(ICLR_OFS, 32'h00000000);
            wr_reg(LOAD_OFS, hl_tab[i]);
            wr_reg(CTRL_OFS, ctl(SRC_OSC, hu_tab[i], 1'b1, 1'b0, hf_tab[i], PSC_DIV256));
            ticks(1'b1, 256);
            chk_rd(COUNT_OFS, he_tab[i], "time format");
            `CHK("time timeout", hi_tab[i], irq)
        end
        // 255-hour range runs out at its own maximum
        wr_reg(ICLR_OFS, 32'h000000a5);
        wr_reg(LOAD_OFS, 32'hff3b3b63);
        wr_reg(CTRL_OFS, ctl(SRC_OSC, 1'b1, 1'b1, 1'b0, FMT_HMS255, PSC_DIV256));
        ticks(1'b1, 256);
        chk_rd(COUNT_OFS, 32'h00000000, "255-hour wrap");
        `CHK("255-hour timeout", 1'b1, irq)
        // reserved format code counts in binary
        wr_reg(LOAD_OFS, 32'h00000100);
        wr_reg(CTRL_OFS, ctl(SRC_OSC, 1'b0, 1'b1, 1'b0, FMT_RSVD, PSC_DIV1));
        ticks(1'b1, 1);
        chk_rd(COUNT_OFS, 32'h000000ff, "reserved format");
        `CHK("trigger total", 6, adc_n)
        complete_run;
    end
endmodule

// >>> verilog/wut_pkg.sv
// shared constants, types and helper functions of the wake-up counter
package wut_pkg;

    // ************************************************************
    // register map and reset values
    // ************************************************************
    localparam int          DATA_W      = 32;
    localparam int          CTRL_W      = 11;
    localparam int          CD_W        = 3;
    localparam int          PSC_CNT_W   = 15;
    localparam logic [31:0] LOAD_OFS    = 32'hffff0340;
    localparam logic [31:0] COUNT_OFS   = 32'hffff0344;
    localparam logic [31:0] CTRL_OFS    = 32'hffff0348;
    localparam logic [31:0] ICLR_OFS    = 32'hffff034c;
    localparam logic [31:0] STAT_OFS    = 32'hffff0350;
    localparam logic [31:0] MASK_OFS    = 32'hffff0354;
    localparam logic [31:0] LOAD_RST    = 32'h00000000;
    localparam logic [31:0] COUNT_RST   = 32'h0fffffff;
    localparam logic [10:0] CTRL_RST    = 11'h000;
    localparam logic [7:0]  ICLR_RST    = 8'hff;
    localparam logic [0:0]  STAT_RST    = 1'h0;
    localparam logic [0:0]  MASK_RST    = 1'h1;

    // ************************************************************
    // control field positions
    // ************************************************************
    localparam int SRC_HI  = 10;
    localparam int SRC_LO  = 9;
    localparam int UP_BIT  = 8;
    localparam int EN_BIT  = 7;
    localparam int PER_BIT = 6;
    localparam int FMT_HI  = 5;
    localparam int FMT_LO  = 4;
    localparam int PSC_HI  = 3;
    localparam int PSC_LO  = 0;

    // ************************************************************
    // encodings and limits
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_XTAL  = 2'b00,
        SRC_XTAL2 = 2'b01,
        SRC_OSC   = 2'b10,
        SRC_CORE  = 2'b11
    } wut_src_t;

    typedef enum logic [1:0] {
        FMT_BIN   = 2'b00,
        FMT_RSVD  = 2'b01,
        FMT_HMS23 = 2'b10,
        FMT_HMS255 = 2'b11
    } wut_fmt_t;

    localparam logic [3:0]  PSC_DIV1    = 4'h0;
    localparam logic [3:0]  PSC_DIV16   = 4'h4;
    localparam logic [3:0]  PSC_DIV256  = 4'h8;
    localparam logic [3:0]  PSC_DIV32K  = 4'hf;
    localparam logic [14:0] LAST_DIV1   = 15'h0000;
    localparam logic [14:0] LAST_DIV16  = 15'h000f;
    localparam logic [14:0] LAST_DIV256 = 15'h00ff;
    localparam logic [14:0] LAST_DIV32K = 15'h7fff;
    localparam logic [7:0]  HUND_MAX    = 8'h63;
    localparam logic [7:0]  SEC_MAX     = 8'h3b;
    localparam logic [7:0]  MIN_MAX     = 8'h3b;
    localparam logic [7:0]  HR23_MAX    = 8'h17;
    localparam logic [7:0]  HR255_MAX   = 8'hff;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } wut_bus_t;

    typedef struct packed {
        logic [31:0]     load;
        logic [31:0]     count;
        logic [10:0]     ctrl;
        logic [0:0]      stat;
        logic [0:0]      mask;
        logic [31:0]     rdata;
        logic            irq;
        logic            adc_trig;
        logic            core_tick;
        logic [6:0]      core_cnt;
    } wut_state_t;

    typedef struct packed {
        logic [14:0] cnt;
        logic        tick;
    } wut_psc_state_t;

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [14:0] wut_psc_last(input logic [3:0] psel);
        unique case (psel)
            PSC_DIV16:  wut_psc_last = LAST_DIV16;
            PSC_DIV256: wut_psc_last = LAST_DIV256;
            PSC_DIV32K: wut_psc_last = LAST_DIV32K;
            default:    wut_psc_last = LAST_DIV1;
        endcase
    endfunction

endpackage

// >>> verilog/wut_prescaler.sv
// source clock prescaler of the wake-up counter
module wut_prescaler (
    input  wire  logic       mclk,
    input  wire  logic       rst,
    input  wire  logic       run,
    input  wire  logic       src_tick,
    input  wire  logic [3:0] psel,
    output logic             tick
);
    import wut_pkg::*;

    wut_psc_state_t st_r;
    wut_psc_state_t st_nxt;
    logic [14:0]    last;

    // ************************************************************
    // divider
    // ************************************************************
    always_comb begin
        last   = wut_psc_last(psel);
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run) begin
            // restart phase so each enable gives a full first period
            st_nxt.cnt = '0;
        end else if (src_tick) begin
            st_nxt.tick = (st_r.cnt >= last);
            st_nxt.cnt  = (st_r.cnt >= last) ? 15'h0000 : st_r.cnt + 15'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            st_r <= '{cnt: 15'h0000, tick: 1'b0};
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;

    // ************************************************************
    // checks
    // ************************************************************
    div16_period_a: assert property (@(posedge mclk) disable iff (rst)
        (tick && psel == PSC_DIV16 && $past(psel) == PSC_DIV16)
        |-> $past(st_r.cnt) == LAST_DIV16)
        else $error("divide-by-16 tick not on count 15");

    div1_pass_a: assert property (@(posedge mclk) disable iff (rst)
        (run && src_tick && psel == PSC_DIV1) |=> tick)
        else $error("divide-by-1 dropped a source tick");

endmodule

// >>> verilog/wut_timer.sv
// wake-up counter top: register port, source select, counter, interrupt
module wut_timer (
    input  wire  logic                 mclk,
    input  wire  logic                 rst,
    input  wire  wut_pkg::wut_bus_t    bus,
    output logic [31:0]                rdata,
    input  wire  logic                 xtal_tick,
    input  wire  logic                 osc_tick,
    input  wire  logic                 core_clk_off,
    input  wire  logic [2:0]           core_clock_divider,
    output logic                       irq,
    output logic                       adc_trigger
);
    import wut_pkg::*;

    wut_state_t st_r;
    wut_state_t st_nxt;
    wut_src_t   src;
    wut_fmt_t   fmt;
    logic       up;
    logic       en;
    logic       periodic;
    logic       src_tick;
    logic       pre_tick;
    logic       at_end;
    logic       timeout;
    logic       wr_load;
    logic       wr_ctrl;
    logic       wr_iclr;
    logic       wr_stat;
    logic       wr_mask;
    logic [6:0] core_last;

    // ************************************************************
    // count arithmetic
    // ************************************************************
    function automatic logic [7:0] wut_hr_max(input wut_fmt_t f);
        wut_hr_max = (f == FMT_HMS23) ? HR23_MAX : HR255_MAX;
    endfunction

    function automatic logic wut_is_hms(input wut_fmt_t f);
        wut_is_hms = (f == FMT_HMS23) || (f == FMT_HMS255);
    endfunction

    // terminal value: zero counting down, full scale or the time format maximum counting up
    function automatic logic wut_at_end(input logic [31:0] v, input logic up,
                                        input wut_fmt_t f);
        if (!up)
            wut_at_end = (v == 32'h00000000);
        else if (wut_is_hms(f))
            wut_at_end = (v == {wut_hr_max(f), MIN_MAX, SEC_MAX, HUND_MAX});
        else
            wut_at_end = (v == 32'hffffffff);
    endfunction

    // one count step; terminal values wrap by themselves
    function automatic logic [31:0] wut_step(input logic [31:0] v, input logic up,
                                             input wut_fmt_t f);
        logic [7:0] h;
        logic [7:0] m;
        logic [7:0] s;
        logic [7:0] c;
        logic       k;
        {h, m, s, c} = v;
        if (!wut_is_hms(f)) begin
            wut_step = up ? v + 32'h00000001 : v - 32'h00000001;
        end else if (up) begin
            k = (c == HUND_MAX);
            c = k ? 8'h00 : c + 8'h01;
            if (k) begin
                k = (s == SEC_MAX);
                s = k ? 8'h00 : s + 8'h01;
            end
            if (k) begin
                k = (m == MIN_MAX);
                m = k ? 8'h00 : m + 8'h01;
            end
            if (k)
                h = (h == wut_hr_max(f)) ? 8'h00 : h + 8'h01;
            wut_step = {h, m, s, c};
        end else begin
            k = (c == 8'h00);
            c = k ? HUND_MAX : c - 8'h01;
            if (k) begin
                k = (s == 8'h00);
                s = k ? SEC_MAX : s - 8'h01;
            end
            if (k) begin
                k = (m == 8'h00);
                m = k ? MIN_MAX : m - 8'h01;
            end
            if (k)
                h = (h == 8'h00) ? wut_hr_max(f) : h - 8'h01;
            wut_step = {h, m, s, c};
        end
    endfunction

    // ************************************************************
    // control decode
    // ************************************************************
    assign src      = wut_src_t'(st_r.ctrl[SRC_HI:SRC_LO]);
    assign fmt      = wut_fmt_t'(st_r.ctrl[FMT_HI:FMT_LO]);
    assign up       = st_r.ctrl[UP_BIT];
    assign en       = st_r.ctrl[EN_BIT];
    assign periodic = st_r.ctrl[PER_BIT];
    assign wr_load  = bus.wr && bus.addr == LOAD_OFS;
    assign wr_ctrl  = bus.wr && bus.addr == CTRL_OFS;
    assign wr_iclr  = bus.wr && bus.addr == ICLR_OFS;
    assign wr_stat  = bus.wr && bus.addr == STAT_OFS;
    assign wr_mask  = bus.wr && bus.addr == MASK_OFS;

    // ************************************************************
    // source select
    // ************************************************************
    always_comb begin
        unique case (src)
            SRC_XTAL, SRC_XTAL2: src_tick = xtal_tick;
            SRC_OSC:             src_tick = osc_tick;
            SRC_CORE:            src_tick = st_r.core_tick;
        endcase
    end

    wut_prescaler u_psc (
        .mclk     (mclk),
        .rst      (rst),
        .run      (en),
        .src_tick (src_tick),
        .psel     (st_r.ctrl[PSC_HI:PSC_LO]),
        .tick     (pre_tick)
    );

    // reserved format code counts as binary
    assign at_end  = wut_at_end(st_r.count, up, fmt);
    assign timeout = en && pre_tick && at_end;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        core_last = 7'((8'h01 << core_clock_divider) - 8'h01);
        st_nxt = st_r;
        st_nxt.adc_trig  = timeout;
        st_nxt.core_tick = 1'b0;
        // crystal and oscillator ticks are independent of the core clock gate
        if (!core_clk_off) begin
            st_nxt.core_tick = (st_r.core_cnt >= core_last);
            st_nxt.core_cnt  = (st_r.core_cnt >= core_last) ? 7'h00
                                                             : st_r.core_cnt + 7'h01;
        end
        if (en && pre_tick) begin
            if (at_end && periodic)
                st_nxt.count = st_r.load;
            else
                st_nxt.count = wut_step(st_r.count, up, fmt);
        end
        if (wr_load) begin
            st_nxt.load  = bus.wdata;
            st_nxt.count = bus.wdata;
        end
        if (wr_ctrl)
            st_nxt.ctrl = bus.wdata[CTRL_W-1:0];
        if (wr_mask)
            st_nxt.mask = bus.wdata[0:0];
        if (wr_iclr)
            st_nxt.stat = 1'b0;
        if (wr_stat && bus.wdata[0])
            st_nxt.stat = 1'b0;
        // a timeout in the clearing cycle is kept
        if (timeout)
            st_nxt.stat = 1'b1;
        st_nxt.irq = st_nxt.stat[0] && st_nxt.mask[0];
        st_nxt.rdata = 32'h00000000;
        if (bus.rd) begin
            unique case (bus.addr)
                LOAD_OFS:  st_nxt.rdata = st_r.load;
                COUNT_OFS: st_nxt.rdata = st_r.count;
                CTRL_OFS:  st_nxt.rdata = {21'h000000, st_r.ctrl};
                STAT_OFS:  st_nxt.rdata = {31'h00000000, st_r.stat};
                MASK_OFS:  st_nxt.rdata = {31'h00000000, st_r.mask};
                default:   st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '{load: LOAD_RST, count: COUNT_RST, ctrl: CTRL_RST, stat: STAT_RST,
                      mask: MASK_RST, rdata: 32'h00000000, irq: 1'b0,
                      adc_trig: 1'b0, core_tick: 1'b0, core_cnt: 7'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata       = st_r.rdata;
    assign irq         = st_r.irq;
    assign adc_trigger = st_r.adc_trig;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    halt_when_off_a: assert property (
        (!en && !wr_load) |=> st_r.count == $past(st_r.count))
        else $error("count moved while disabled");

    load_write_a: assert property (
        wr_load |=> (st_r.count == $past(bus.wdata)) && (st_r.load == $past(bus.wdata)))
        else $error("load write not taken");

    count_ro_a: assert property (
        (bus.wr && bus.addr == COUNT_OFS && !pre_tick)
        |=> st_r.count == $past(st_r.count) && st_r.load == $past(st_r.load))
        else $error("write to count register had an effect");

    down_step_a: assert property (
        (en && pre_tick && !up && fmt == FMT_BIN && !at_end && !wr_load)
        |=> st_r.count == $past(st_r.count) - 32'h00000001)
        else $error("binary down step wrong");

    up_step_a: assert property (
        (en && pre_tick && up && fmt == FMT_BIN && !at_end && !wr_load)
        |=> st_r.count == $past(st_r.count) + 32'h00000001)
        else $error("binary up step wrong");

    periodic_reload_a: assert property (
        (timeout && periodic && !wr_load) |=> st_r.count == st_r.load)
        else $error("periodic mode did not reload");

    free_wrap_a: assert property (
        (timeout && !periodic && !up && fmt == FMT_BIN && !wr_load)
        |=> st_r.count == 32'hffffffff)
        else $error("free-running down count did not wrap");

    hms_wrap_a: assert property (
        (timeout && !periodic && !up && fmt == FMT_HMS23 && !wr_load)
        |=> st_r.count == {HR23_MAX, MIN_MAX, SEC_MAX, HUND_MAX})
        else $error("23-hour format wrapped to wrong value");

    irq_hold_a: assert property (
        (st_r.stat[0] && !wr_iclr && !(wr_stat && bus.wdata[0])) |=> st_r.stat[0])
        else $error("pending interrupt dropped without a clear");

    irq_clear_a: assert property (
        (wr_iclr && !timeout) |=> !st_r.stat[0] ##1 !irq || st_r.stat[0])
        else $error("clear write left interrupt pending");

    irq_level_a: assert property (
        timeout && st_r.mask[0] && !wr_mask |=> irq)
        else $error("timeout did not raise interrupt");

    trig_pulse_a: assert property (
        timeout |=> adc_trigger)
        else $error("timeout trigger missing");

    core_gate_a: assert property (
        (core_clk_off && src == SRC_OSC && osc_tick && en
         && st_r.ctrl[PSC_HI:PSC_LO] == PSC_DIV1) |=> pre_tick)
        else $error("oscillator count stalled with core clock off");

    other_src_a: assert property (
        (src == SRC_OSC && !osc_tick) |=> !pre_tick)
        else $error("unselected source reached the prescaler");

    trig_only_a: assert property (
        !timeout |=> !adc_trigger)
        else $error("trigger without a timeout");

    rdata_idle_a: assert property (
        !bus.rd |=> rdata == 32'h00000000)
        else $error("read data stood past its cycle");

    hms255_wrap_a: assert property (
        (timeout && !periodic && up && fmt == FMT_HMS255 && !wr_load)
        |=> st_r.count == 32'h00000000)
        else $error("255-hour format did not wrap to zero");

    load_kept_a: assert property (
        !wr_load |=> st_r.load == $past(st_r.load))
        else $error("load value changed without a write");

    cov_rsvd_c:     cover property (en && pre_tick && fmt == FMT_RSVD);
    cov_periodic_c: cover property (timeout && periodic);
    cov_hms_c:      cover property (timeout && fmt == FMT_HMS255);
    cov_irq_c:      cover property (irq ##1 wr_iclr);
    cov_core_c:     cover property (src == SRC_CORE && pre_tick);

endmodule
